/* File: hw/vsac_pkg.sv */
/*
  Constants, command nibbles, user operations and sequencer states for the
  host-side controller of the voice recorder chip.
  Assumes a 20 MHz system clock; pin timings given in ns are derived from it, clear timings are given in cycles.
*/
`default_nettype none
package vsac_pkg;
  localparam int CLK_MHZ = 20;
  // Pin timings in their own units, with the derived cycle counts; clear timings in cycles only
  localparam int WR_PULSE_NS = 400;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_HOLD_NS = 200;
  localparam int WR_HOLD_CYC = (WR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_PULSE_NS = 3000;
  localparam int RD_PULSE_CYC = (RD_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RWL_NS = 100;
  localparam int RWL_CYC = (RWL_NS * CLK_MHZ + 999) / 1000;
  localparam int WRL_NS = 1000;
  localparam int WRL_CYC = (WRL_NS * CLK_MHZ + 999) / 1000;
  localparam int MIC_WAIT_MS = 100;
  localparam int MIC_WAIT_CYC = MIC_WAIT_MS * CLK_MHZ * 1000;
  localparam int ACL_HOLD_CYC = 16;
  localparam int CLEAR_WAIT_CYC = 4000;
  // Memory layout
  localparam logic [19:0] INDEX_TOP = 20'h0_00ff;
  localparam logic [5:0] MAX_AUTO_PHRASE = 6'h10;
  // Command nibbles written on the data pins
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_REC_WAIT = 4'h1;
  localparam logic [3:0] CMD_PLAY_WAIT = 4'h2;
  localparam logic [3:0] CMD_START = 4'h3;
  localparam logic [3:0] CMD_STOP = 4'h4;
  localparam logic [3:0] CMD_ADLD1 = 4'h5;
  localparam logic [3:0] CMD_ADLD2 = 4'h6;
  localparam logic [3:0] MEMORY_BYTE_READ_CMD = 4'h7;
  localparam logic [3:0] ADDRESS_READBACK_CMD = 4'h8;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_REC_WAIT = 4'h1, OP_PLAY_WAIT = 4'h2,
    OP_START = 4'h3, OP_STOP = 4'h4, OP_STBY_ON = 4'h5,
    OP_STBY_OFF = 4'h6, OP_READ_BYTE = 4'h7, OP_ADDR_READ = 4'h8,
    OP_SET_DIRECT = 4'h9, OP_DMA_ON = 4'ha, OP_DMA_OFF = 4'hb,
    OP_CLEAR = 4'hc
  } vsac_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_WR_LOW = 4'h1, ST_WR_HOLD = 4'h2,
    ST_RD_LOW = 4'h3, ST_RD_GAP = 4'h4, ST_ACL = 4'h5,
    ST_CLR_WAIT = 4'h6, ST_DMA_WR = 4'h7, ST_REL_RD = 4'h8,
    ST_REL_WR = 4'h9
  } vsac_state_t;
endpackage
`default_nettype wire

/* File: hw/vsac_host.sv */
/*
  Host controller that drives the voice recorder chip through its 4-bit
  command bus, read/write strobes, clear, standby and capacity pins.
  Assumes the chip samples nibbles on the rising write strobe, and that its
  end-of-sequence output is synchronous to clk_sys.
*/
// Notes on behaviour
// - While recording or playing, host issues only stop.
// - Standby entered only from a recording or playback waiting state.
// - Recording phrase numbers go in ascending order from lowest.
// - With automatic phrases, numbers above 16 are never accessed.
// - Direct start and stop addresses stay out of index area.
// - Direct stop address is greater than start address.
// - Host waits the processing time before reading back data.
// - Leave hand-over: read strobe high, write strobe high, then NOP.
// - Up to four chips, all of one capacity.
// - Wait about 100 ms after play-wait to record-wait before recording.
`timescale 1ns/1ps
`default_nettype none
module vsac_host
  import vsac_pkg::*;
#(
  parameter int MIC_WAIT = MIC_WAIT_CYC,
  parameter bit BIG_SRAM = 1'b1
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Synchronous reset, low
  input wire logic ce, // Clock enable
  input wire logic op_valid, // Operation request
  input wire logic [3:0] op_code, // Operation, vsac_op_t
  input wire logic [5:0] op_phrase, // Phrase number
  input wire logic [19:0] op_start, // Direct start address
  input wire logic [19:0] op_stop, // Direct stop address
  input wire logic direct_mode, // Chip runs in direct mode
  input wire logic eos, // End of sequence from chip
  input wire logic [3:0] dbus_in, // Chip data pins, read side
  output logic [3:0] dbus_out, // Chip data pins, drive side
  output logic dbus_oe, // Chip data pins driven
  output logic rd_n, // Read strobe
  output logic wr_n, // Write strobe
  output logic async_clear_input_n, // Chip clear
  output logic stby, // Chip standby
  output logic capacity_select_pin, // High for CAPACITY_SELECT_PIN parts
  output logic op_ready, // Ready for an operation
  output logic op_done, // Operation finished
  output logic op_err, // Operation refused
  output logic [19:0] rd_data, // Read-back data
  output logic rec_waiting, // Chip in record waiting state
  output logic dev_busy, // Chip recording or playing
  output logic dma_held // Memory bus handed over
);
  vsac_state_t st;
  logic [47:0] nib_buf;
  logic [3:0] nib_left;
  logic [2:0] rd_left;
  logic [2:0] rd_idx;
  logic [11:0] tmr;
  logic [20:0] mic_cnt;
  logic legal;
  logic accept;
  vsac_op_t op;

  // One strap for all fitted chips; mixed capacities are not supported
  assign capacity_select_pin = BIG_SRAM;
  assign op = vsac_op_t'(op_code);
  assign op_ready = ce && (st == ST_IDLE);
  assign accept = op_ready && op_valid && legal;

  always_comb begin
    legal = 1'b1;
    if (dma_held) begin
      legal = (op == OP_DMA_OFF);
    end else if (stby) begin
      legal = (op == OP_STBY_OFF);
    end else if (dev_busy) begin
      legal = (op == OP_STOP);
    end else begin
      unique case (op)
        OP_START: begin
          if (rec_waiting && mic_cnt != 21'h0_0000) begin
            legal = 1'b0;
          end else if (!direct_mode) begin
            legal = (op_phrase <= MAX_AUTO_PHRASE);
          end
        end
        OP_SET_DIRECT: begin
          legal = direct_mode && op_start > INDEX_TOP
            && op_stop > INDEX_TOP
            && op_stop > op_start;
        end
        OP_DMA_OFF, OP_STBY_OFF: legal = 1'b0;
        default: legal = 1'b1;
      endcase
    end
  end

  // Recording phrase counter shares the ascending check
  logic [5:0] next_phrase;
  logic phrase_bad;
  assign phrase_bad = (op == OP_START) && rec_waiting && !direct_mode
    && !dev_busy && (op_phrase != next_phrase);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      op_err <= 1'b0;
    end else if (ce) begin
      op_err <= op_ready && op_valid && (!legal || phrase_bad);
    end
  end

  // Chip mode as the host has commanded it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rec_waiting <= 1'b0;
      dev_busy <= 1'b0;
      stby <= 1'b0;
      next_phrase <= 6'h00;
    end else if (ce) begin
      if (accept && !phrase_bad) begin
        unique case (op)
          OP_REC_WAIT: rec_waiting <= 1'b1;
          OP_PLAY_WAIT: rec_waiting <= 1'b0;
          OP_START: begin
            dev_busy <= 1'b1;
            if (rec_waiting && !direct_mode) begin
              next_phrase <= next_phrase + 6'h01;
            end
          end
          OP_STOP: dev_busy <= 1'b0;
          OP_STBY_ON: stby <= 1'b1;
          OP_STBY_OFF: stby <= 1'b0;
          OP_CLEAR: begin
            rec_waiting <= 1'b0;
            dev_busy <= 1'b0;
            next_phrase <= 6'h00;
          end
          default: ;
        endcase
      end else if (eos) begin
        dev_busy <= 1'b0;
      end
    end
  end

  // Amplifier settling time after entering record waiting
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mic_cnt <= 21'h0_0000;
    end else if (ce) begin
      if (accept && op == OP_REC_WAIT && !rec_waiting) begin
        mic_cnt <= 21'(MIC_WAIT);
      end else if (mic_cnt != 21'h0_0000) begin
        mic_cnt <= mic_cnt - 21'h0_0001;
      end
    end
  end

  // Pin sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= ST_IDLE;
      nib_buf <= 48'h0000_0000_0000;
      nib_left <= 4'h0;
      rd_left <= 3'h0;
      rd_idx <= 3'h0;
      tmr <= 12'h000;
      dbus_out <= 4'h0;
      dbus_oe <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      async_clear_input_n <= 1'b1;
      rd_data <= 20'h0_0000;
      dma_held <= 1'b0;
      op_done <= 1'b0;
    end else if (ce) begin
      op_done <= 1'b0;
      unique case (st)
        ST_IDLE: begin
          if (accept && !phrase_bad) begin
            rd_left <= 3'h0;
            rd_idx <= 3'h0;
            tmr <= 12'(WR_PULSE_CYC);
            st <= ST_WR_LOW;
            unique case (op)
              OP_REC_WAIT: {nib_left, nib_buf} <= {4'h1, 44'h0, CMD_REC_WAIT};
              OP_PLAY_WAIT: {nib_left, nib_buf} <= {4'h1, 44'h0, CMD_PLAY_WAIT};
              OP_START: begin
                nib_buf <= {36'h0, 2'b00, op_phrase, CMD_START};
                nib_left <= direct_mode ? 4'h1 : 4'h3;
              end
              OP_STOP: {nib_left, nib_buf} <= {4'h1, 44'h0, CMD_STOP};
              OP_READ_BYTE: begin
                {nib_left, nib_buf} <= {4'h1, 44'h0, MEMORY_BYTE_READ_CMD};
                rd_left <= 3'h2;
                rd_data <= 20'h0_0000;
              end
              OP_ADDR_READ: begin
                {nib_left, nib_buf} <= {4'h1, 44'h0, ADDRESS_READBACK_CMD};
                rd_left <= 3'h5;
                rd_data <= 20'h0_0000;
              end
              OP_SET_DIRECT: begin
                nib_buf <= {op_stop, CMD_ADLD2, op_start, CMD_ADLD1};
                nib_left <= 4'hc;
              end
              OP_CLEAR: begin
                async_clear_input_n <= 1'b0;
                tmr <= 12'(ACL_HOLD_CYC);
                st <= ST_ACL;
              end
              OP_DMA_ON: begin
                wr_n <= 1'b0;
                tmr <= 12'(WRL_CYC);
                st <= ST_DMA_WR;
              end
              OP_DMA_OFF: begin
                rd_n <= 1'b1;
                tmr <= 12'(RWL_CYC);
                st <= ST_REL_RD;
              end
              default: begin
                op_done <= 1'b1;
                st <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WR_LOW: begin
          dbus_oe <= 1'b1;
          dbus_out <= nib_buf[3:0];
          wr_n <= 1'b0;
          tmr <= tmr - 12'h001;
          // Count to zero so the strobe stays low for the full count
          if (tmr == 12'h000) begin
            wr_n <= 1'b1;
            tmr <= 12'(WR_HOLD_CYC);
            st <= ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          tmr <= tmr - 12'h001;
          if (tmr == 12'h001) begin
            dbus_oe <= 1'b0;
            nib_buf <= {4'h0, nib_buf[47:4]};
            nib_left <= nib_left - 4'h1;
            if (nib_left != 4'h1) begin
              tmr <= 12'(WR_PULSE_CYC);
              st <= ST_WR_LOW;
            end else if (rd_left != 3'h0) begin
              // Long low read strobe covers the processing time
              tmr <= 12'(RD_PULSE_CYC);
              st <= ST_RD_LOW;
            end else begin
              op_done <= 1'b1;
              st <= ST_IDLE;
            end
          end
        end
        ST_RD_LOW: begin
          rd_n <= 1'b0;
          tmr <= tmr - 12'h001;
          // Sample while still low, after the full processing time
          if (tmr == 12'h000) begin
            rd_data[4 * rd_idx +: 4] <= dbus_in;
            rd_idx <= rd_idx + 3'h1;
            rd_left <= rd_left - 3'h1;
            rd_n <= 1'b1;
            tmr <= 12'(WR_HOLD_CYC);
            st <= ST_RD_GAP;
          end
        end
        ST_RD_GAP: begin
          tmr <= tmr - 12'h001;
          if (tmr == 12'h001) begin
            if (rd_left != 3'h0) begin
              tmr <= 12'(RD_PULSE_CYC);
              st <= ST_RD_LOW;
            end else begin
              op_done <= 1'b1;
              st <= ST_IDLE;
            end
          end
        end
        ST_ACL: begin
          tmr <= tmr - 12'h001;
          if (tmr == 12'h001) begin
            async_clear_input_n <= 1'b1;
            // Chip presets its counters and clears the index area now
            tmr <= 12'(CLEAR_WAIT_CYC);
            st <= ST_CLR_WAIT;
          end
        end
        ST_CLR_WAIT: begin
          tmr <= tmr - 12'h001;
          if (tmr == 12'h001) begin
            op_done <= 1'b1;
            st <= ST_IDLE;
          end
        end
        ST_DMA_WR: begin
          tmr <= tmr - 12'h001;
          if (tmr == 12'h001) begin
            rd_n <= 1'b0;
            dma_held <= 1'b1;
            op_done <= 1'b1;
            st <= ST_IDLE;
          end
        end
        ST_REL_RD: begin
          tmr <= tmr - 12'h001;
          if (tmr == 12'h001) begin
            wr_n <= 1'b1;
            tmr <= 12'(WRL_CYC);
            st <= ST_REL_WR;
          end
        end
        ST_REL_WR: begin
          tmr <= tmr - 12'h001;
          if (tmr == 12'h001) begin
            dma_held <= 1'b0;
            {nib_left, nib_buf} <= {4'h1, 44'h0, CMD_NOP};
            tmr <= 12'(WR_PULSE_CYC);
            st <= ST_WR_LOW;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end
endmodule // vsac_host
`default_nettype wire

/* File: dv/vsac_host_chk.sv */
/*
  Assertion checker for vsac_host, bound to its ports.
  Assumes one clock, synchronous low reset, MIC_WAIT as in the design.
*/
`timescale 1ns/1ps
`default_nettype none
module vsac_host_chk
  import vsac_pkg::*;
#(
  parameter int MIC_WAIT = 50
) (
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset, low
  input wire logic op_valid, // Request
  input wire logic [3:0] op_code, // Operation
  input wire logic [5:0] op_phrase, // Phrase
  input wire logic [19:0] op_start, // Start address
  input wire logic [19:0] op_stop, // Stop address
  input wire logic direct_mode, // Direct mode
  input wire logic eos, // End of sequence
  input wire logic op_ready, // Ready
  input wire logic op_err, // Refused
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic stby, // Standby
  input wire logic rec_waiting, // Record waiting
  input wire logic dev_busy, // Busy
  input wire logic dma_held // Bus handed over
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  int rw_cnt;
  int rd_cnt;
  logic take;
  assign take = op_valid && op_ready;
  // Margin of 16: the design may start its timer at the request
  always_ff @(posedge clk_sys) begin
    rw_cnt <= (!nrst || !rec_waiting) ? 0 : rw_cnt + 1;
  end
  always_ff @(posedge clk_sys) begin
    rd_cnt <= (!nrst || rd_n) ? 0 : rd_cnt + 1;
  end
  chk_busy_only_stop: assert property (
    take && dev_busy && !eos && op_code != OP_STOP |=> op_err)
    else $error("request other than stop taken while busy");
  chk_stby_entry: assert property (
    $rose(stby) |-> !$past(dev_busy) && !$past(dma_held))
    else $error("standby entered outside a waiting state");
  chk_phrase_limit: assert property (
    take && op_code == OP_START && !direct_mode && op_phrase > 6'h10
    |=> op_err) else $error("phrase above limit taken");
  chk_direct_range: assert property (
    take && op_code == OP_SET_DIRECT &&
    (op_start <= INDEX_TOP || op_stop <= op_start) |=> op_err)
    else $error("bad direct addresses taken");
  chk_release_order: assert property (
    $rose(wr_n) && $past(nrst) |-> $past(rd_n) && $past(rd_n, 2))
    else $error("write strobe released before read strobe");
  chk_handover_order: assert property (
    $fell(rd_n) && !wr_n |-> !$past(wr_n) && !$past(wr_n, 19))
    else $error("read strobe lowered too soon after write strobe");
  chk_mic_settle: assert property (
    take && rec_waiting && op_code == OP_START && rw_cnt + 16 < MIC_WAIT
    |=> op_err) else $error("start taken before amplifier settled");
  chk_read_time: assert property (
    $rose(rd_n) && $past(nrst) && wr_n |-> rd_cnt >= RD_PULSE_CYC)
    else $error("read strobe shorter than processing time");
endmodule // vsac_host_chk
bind vsac_host vsac_host_chk #(.MIC_WAIT(MIC_WAIT)) i_vsac_host_chk (
  .clk_sys(clk_sys), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
  .op_phrase(op_phrase), .op_start(op_start), .op_stop(op_stop),
  .direct_mode(direct_mode), .eos(eos), .op_ready(op_ready),
  .op_err(op_err), .rd_n(rd_n), .wr_n(wr_n), .stby(stby),
  .rec_waiting(rec_waiting), .dev_busy(dev_busy), .dma_held(dma_held)
);
`default_nettype wire

/* File: dv/vsac_dev_model.sv */
/*
  Behavioural model of the recorder chip's command side.
  Assumes resolved data pins and strobes sampled on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module vsac_dev_model
  import vsac_pkg::*;
#(
  parameter int RUN_CYC = 400,
  parameter logic [7:0] DATA_BYTE = 8'h5a
) (
  input wire logic clk_sys, // Clock
  input wire logic [3:0] pins, // Resolved data pins
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic clr_n, // Clear
  output logic [3:0] dev_dat, // Nibble driven
  output logic dev_oe, // Drives the pins
  output logic eos, // End of sequence
  output logic [3:0] cmd, // Last command
  output logic [19:0] addr_q, // Address counter
  output logic [19:0] stop_q, // Stop address
  output logic mic_on // Amplifier active
);
  logic [19:0] arg, sh;
  logic wr_d, rd_d, clr_d;
  int args, rd_idx, run;
  initial begin
    {cmd, arg, sh, eos, mic_on, args, rd_idx, run} = '0;
    {wr_d, rd_d, clr_d} = 3'h7;
  end
  assign dev_oe = !rd_n && wr_n;
  assign dev_dat = 4'(sh >> (4 * rd_idx));
  always @(posedge clk_sys) begin
    eos <= 1'b0;
    if (run > 0) begin
      run <= run - 1;
      addr_q <= addr_q + 20'h0_0001;
      eos <= (run == 1);
    end
    if (clr_n && !clr_d) begin
      addr_q <= 20'h0_0100;
      stop_q <= 20'h0_0100;
      // Clear leaves the chip in playback waiting
      mic_on <= 1'b0;
    end
    if (rd_n && !rd_d && wr_n) rd_idx <= rd_idx + 1;
    if (wr_n && !wr_d && rd_n) begin
      rd_idx <= 0;
      if (args > 0) begin
        arg = {pins, arg[19:4]};
        args <= args - 1;
        if (args == 1 && cmd == CMD_ADLD1) addr_q <= arg;
        if (args == 1 && cmd == CMD_ADLD2) stop_q <= arg;
        if (args == 1 && cmd == CMD_START) run <= RUN_CYC;
      end else begin
        cmd <= pins;
        args <= (pins == CMD_START) ? 2 :
          (pins == CMD_ADLD1 || pins == CMD_ADLD2) ? 5 : 0;
        // Index area reads back cleared
        sh <= (pins == ADDRESS_READBACK_CMD) ? addr_q :
          {12'h000, (addr_q <= INDEX_TOP) ? 8'h00 : DATA_BYTE};
        if (pins == CMD_STOP) run <= 0;
        if (pins == CMD_REC_WAIT) mic_on <= 1'b1;
        if (pins == CMD_PLAY_WAIT) mic_on <= 1'b0;
      end
    end
    {wr_d, rd_d, clr_d} <= {wr_n, rd_n, clr_n};
  end
endmodule // vsac_dev_model
`default_nettype wire

/* File: dv/tb_top.sv */
/*
  Self-checking bench for vsac_host against the chip model.
  Assumes the checker is bound in and MIC_WAIT shortened to 50.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import vsac_pkg::*;
;
  localparam int MIC = 50;
  logic clk_sys = 1'b0, nrst = 1'b0, op_valid = 1'b0, direct_mode = 1'b0;
  logic [3:0] op_code = 4'h0, dbus_out, dbus_in, dev_dat, cmd;
  logic [5:0] op_phrase = 6'h00;
  logic [19:0] op_start = 20'h0_0000, op_stop = 20'h0_0000;
  logic [19:0] rd_data, addr_q, stop_q;
  logic dbus_oe, rd_n, wr_n, clr_n, stby, cap, op_ready, op_done, op_err;
  logic rec_waiting, dev_busy, dma_held, eos, dev_oe, mic_on;
  int err_count = 0, compares = 0, cyc = 0;
  // Data pins pull down when nobody drives them
  assign dbus_in = dbus_oe ? dbus_out : (dev_oe ? dev_dat : 4'h0);
  always #25 clk_sys = ~clk_sys;
  vsac_host #(.MIC_WAIT(MIC), .BIG_SRAM(1'b1)) i_vsac_host (
    .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .op_valid(op_valid),
    .op_code(op_code), .op_phrase(op_phrase), .op_start(op_start),
    .op_stop(op_stop), .direct_mode(direct_mode), .eos(eos),
    .dbus_in(dbus_in), .dbus_out(dbus_out), .dbus_oe(dbus_oe), .rd_n(rd_n),
    .wr_n(wr_n), .async_clear_input_n(clr_n), .stby(stby),
    .capacity_select_pin(cap), .op_ready(op_ready), .op_done(op_done),
    .op_err(op_err), .rd_data(rd_data), .rec_waiting(rec_waiting),
    .dev_busy(dev_busy), .dma_held(dma_held));
  vsac_dev_model i_vsac_dev_model (.clk_sys(clk_sys), .pins(dbus_in),
    .rd_n(rd_n), .wr_n(wr_n), .clr_n(clr_n), .dev_dat(dev_dat),
    .dev_oe(dev_oe), .eos(eos), .cmd(cmd), .addr_q(addr_q), .stop_q(stop_q),
    .mic_on(mic_on));
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [19:0] seen, exp, input string nm);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until taken; outcome judged on the done or refused pulse
  task automatic do_op(input vsac_op_t c, input logic [5:0] ph, input logic e);
    int n = 0;
    @(negedge clk_sys);
    {op_valid, op_code, op_phrase} = {1'b1, c, ph};
    while (op_ready !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && op_err !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    chk({n < 9000, op_err}, {1'b1, e}, c.name());
  endtask
  task automatic t_clear;
    chk(cap, 1'b1, "capacity select");
    do_op(OP_CLEAR, 6'h00, 1'b0);
    do_op(OP_ADDR_READ, 6'h00, 1'b0);
    chk(rd_data, 20'h0_0100, "address after clear");
    do_op(OP_READ_BYTE, 6'h00, 1'b0);
    chk(rd_data[7:0], 8'h5a, "byte read");
  endtask
  task automatic t_direct;
    logic [19:0] tbl [6] = '{20'h0_00ff, 20'h0_0200, 20'h0_0300,
      20'h0_0200, 20'h0_0200, 20'h0_0300};
    direct_mode = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {op_start, op_stop} = {tbl[2 * i], tbl[2 * i + 1]};
      do_op(OP_SET_DIRECT, 6'h00, i < 2);
    end
    do_op(OP_ADDR_READ, 6'h00, 1'b0);
    chk(rd_data, 20'h0_0200, "direct start");
    chk(stop_q, 20'h0_0300, "direct stop");
    direct_mode = 1'b0;
  endtask
  task automatic t_rec;
    int n = 0;
    do_op(OP_REC_WAIT, 6'h00, 1'b0);
    chk(rec_waiting, 1'b1, "record waiting");
    chk(mic_on, 1'b1, "amplifier on");
    do_op(OP_START, 6'h00, 1'b1);
    repeat (MIC) @(negedge clk_sys);
    do_op(OP_START, 6'h01, 1'b1);
    do_op(OP_START, 6'h11, 1'b1);
    do_op(OP_START, 6'h00, 1'b0);
    chk(dev_busy, 1'b1, "busy");
    do_op(OP_REC_WAIT, 6'h00, 1'b1);
    do_op(OP_STOP, 6'h00, 1'b0);
    chk(dev_busy, 1'b0, "busy after stop");
    do_op(OP_START, 6'h01, 1'b0);
    while (dev_busy === 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(dev_busy, 1'b0, "busy after end");
    do_op(OP_PLAY_WAIT, 6'h00, 1'b0);
    chk({rec_waiting, mic_on}, 2'b00, "play waiting");
  endtask
  task automatic t_stby_dma;
    do_op(OP_STBY_ON, 6'h00, 1'b0);
    chk(stby, 1'b1, "standby");
    do_op(OP_REC_WAIT, 6'h00, 1'b1);
    do_op(OP_STBY_OFF, 6'h00, 1'b0);
    chk(stby, 1'b0, "standby off");
    do_op(OP_DMA_OFF, 6'h00, 1'b1);
    do_op(OP_DMA_ON, 6'h00, 1'b0);
    chk({dma_held, rd_n, wr_n}, 3'h4, "hand-over pins");
    do_op(OP_NOP, 6'h00, 1'b1);
    do_op(OP_DMA_OFF, 6'h00, 1'b0);
    chk({dma_held, rd_n, wr_n, cmd}, {3'h3, CMD_NOP}, "release");
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    t_clear;
    t_direct;
    t_rec;
    t_stby_dma;
    end_sim;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      end_sim;
    end
  end
endmodule // tb_top
`default_nettype wire
